// ---- src/spic_ctrl.sv ----
// Serial peripheral controller with transmit FIFO, master and slave engines
`timescale 1ns/10ps

module spic_fifo
  import spic_pkg::*;
#(
  parameter int unsigned W = 32,
  parameter int unsigned D = 32
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         flush,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  input  wire logic         out_ready,
  output logic              out_valid,
  output logic [W-1:0]      out_data
);
  localparam int unsigned AW = $clog2(D);

  logic [W-1:0]  mem_q [D];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] wr_d;
  logic [AW-1:0] rd_q;
  logic [AW-1:0] rd_d;
  logic [AW:0]   cnt_q;
  logic [AW:0]   cnt_d;
  logic          ready_q;
  logic          ready_d;
  logic          valid_q;
  logic          valid_d;
  logic          push;
  logic          pop;

  assign push      = in_valid && ready_q;
  assign pop       = out_ready && valid_q;
  assign in_ready  = ready_q;
  assign out_valid = valid_q;
  assign out_data  = mem_q[rd_q];

  always_comb begin
    wr_d  = push ? wr_q + AW'(1) : wr_q;
    rd_d  = pop ? rd_q + AW'(1) : rd_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    if (flush) begin
      wr_d  = '0;
      rd_d  = '0;
      cnt_d = '0;
    end
    ready_d = cnt_d != (AW+1)'(D);
    valid_d = cnt_d != '0;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q    <= '0;
      rd_q    <= '0;
      cnt_q   <= '0;
      ready_q <= 1'b0;
      valid_q <= 1'b0;
    end else begin
      wr_q    <= wr_d;
      rd_q    <= rd_d;
      cnt_q   <= cnt_d;
      ready_q <= ready_d;
      valid_q <= valid_d;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
endmodule

// Function
// - With hold and divisor 1, a repeat to one slave after idle misses ready
// - Static select with hold: marker bit 24 releases select once transmit empties
// - Serial clock toggles on configuration writes while master select is clear
// - Static select: DMA size from configuration 0 width; above 8 gives halfword
// - Divisor 1 with odd width 9 to 15 adds one serial clock pulse
// - Disable command has no effect in slave mode
// - Polarity 1, phase 0: slow then divisor-1 transfer adds one pulse
module spic_ctrl
  import spic_pkg::*;
(
  input  wire logic                       sys_clk,
  input  wire logic                       reset_n,
  input  wire logic                       enable_cmd,
  input  wire logic                       disable_cmd,
  input  wire logic                       soft_reset_cmd,
  input  wire logic                       master_select_bit,
  input  wire logic                       fixed_select,
  input  wire logic [1:0]                 cs_select,
  input  wire spic_cs_cfg_t [NUM_CS-1:0]  chip_select_config_regs,
  input  wire logic                       tx_valid,
  input  wire spic_tx_word_t              tx_word,
  output logic                            tx_ready,
  output logic                            transmit_ready_flag,
  output logic                            transmit_empty_flag,
  output logic                            dma_halfword,
  output logic                            enabled,
  output logic                            rx_valid,
  output logic [SHIFT_W-1:0]              rx_data,
  input  wire logic                       rx_ready,
  output logic                            serial_clock_out,
  output logic                            mosi_out,
  output logic                            master_oe,
  output logic [NUM_CS-1:0]               cs_n_out,
  input  wire logic                       miso_in,
  input  wire logic                       sclk_in,
  input  wire logic                       ss_n_in,
  input  wire logic                       mosi_in,
  output logic                            miso_out,
  output logic                            miso_oe
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] pin_meta_q;
  logic [3:0] pin_sync_q;
  logic       sclk_prev_q;
  logic       ss_prev_q;
  logic       miso_s;
  logic       sclk_s;
  logic       ss_n_s;
  logic       mosi_s;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_meta_q  <= 4'h4;
      pin_sync_q  <= 4'h4;
      sclk_prev_q <= 1'b0;
      ss_prev_q   <= 1'b1;
    end else begin
      pin_meta_q  <= {mosi_in, ss_n_in, sclk_in, miso_in};
      pin_sync_q  <= pin_meta_q;
      sclk_prev_q <= pin_sync_q[1];
      ss_prev_q   <= pin_sync_q[2];
    end
  end

  assign miso_s = pin_sync_q[0];
  assign sclk_s = pin_sync_q[1];
  assign ss_n_s = pin_sync_q[2];
  assign mosi_s = pin_sync_q[3];

  // ----------------------------------------------------------------
  // Transmit FIFO
  // ----------------------------------------------------------------
  logic          fifo_valid;
  logic          pop;
  logic          flush;
  logic [31:0]   fifo_raw;
  spic_tx_word_t fifo_word;

  assign fifo_word = spic_tx_word_t'(fifo_raw);
  assign flush     = soft_reset_cmd;

  spic_fifo #(
    .W (FIFO_W),
    .D (FIFO_D)
  ) u_fifo (
    .clk       (sys_clk),
    .rst_n     (reset_n),
    .flush     (flush),
    .in_valid  (tx_valid),
    .in_data   (tx_word),
    .in_ready  (tx_ready),
    .out_ready (pop),
    .out_valid (fifo_valid),
    .out_data  (fifo_raw)
  );

  // ----------------------------------------------------------------
  // Transfer engine
  // ----------------------------------------------------------------
  spic_state_t              state_q, state_d;
  spic_cs_cfg_t [NUM_CS-1:0] cfg_prev_q, cfg_prev_d;
  logic [7:0]  cnt_q, cnt_d;
  logic [5:0]  edge_q, edge_d;
  logic [5:0]  target_q, target_d;
  logic [4:0]  scnt_q, scnt_d;
  logic [15:0] shreg_q, shreg_d;
  logic [15:0] rxsh_q, rxsh_d;
  logic [1:0]  cur_cs_q, cur_cs_d;
  logic [1:0]  last_cs_q, last_cs_d;
  logic [3:0]  cs_n_q, cs_n_d;
  logic        sclk_q, sclk_d;
  logic        mosi_q, mosi_d;
  logic        miso_q, miso_d;
  logic        miso_oe_q, miso_oe_d;
  logic        idle_seen_q, idle_seen_d;
  logic        prev_slow_q, prev_slow_d;
  logic        marker_q, marker_d;
  logic        txr_q, txr_d;
  logic        txe_q, txe_d;
  logic        rxv_q, rxv_d;
  logic [15:0] rxd_q, rxd_d;
  logic        en_q, en_d;
  logic        dmahw_q, dmahw_d;
  logic        moe_q, moe_d;

  spic_cs_cfg_t cur_cfg;
  spic_cs_cfg_t new_cfg;
  spic_cs_cfg_t slv_cfg;
  logic [1:0]   new_cs;
  logic [7:0]   div_eff;
  logic [4:0]   nbits;
  logic [4:0]   new_nbits;
  logic         lead;
  logic         capture;
  logic         repeat_bug;
  logic         extra;
  logic         s_lead;
  logic         s_capture;

  assign cur_cfg = chip_select_config_regs[cur_cs_q];
  assign new_cs  = fixed_select ? cs_select : fifo_word.pcs[1:0];
  assign new_cfg = chip_select_config_regs[new_cs];
  assign slv_cfg = chip_select_config_regs[0];
  assign div_eff = (cur_cfg.serial_clock_divisor == 8'h00) ? DIV_ONE
                                                           : cur_cfg.serial_clock_divisor;
  assign nbits     = spic_nbits(cur_cfg.width_code);
  assign new_nbits = spic_nbits(new_cfg.width_code);

  always_comb begin
    state_d     = state_q;
    cfg_prev_d  = chip_select_config_regs;
    cnt_d       = cnt_q;
    edge_d      = edge_q;
    target_d    = target_q;
    scnt_d      = scnt_q;
    shreg_d     = shreg_q;
    rxsh_d      = rxsh_q;
    cur_cs_d    = cur_cs_q;
    last_cs_d   = last_cs_q;
    cs_n_d      = cs_n_q;
    sclk_d      = sclk_q;
    mosi_d      = mosi_q;
    miso_d      = miso_q;
    miso_oe_d   = miso_oe_q;
    idle_seen_d = idle_seen_q;
    prev_slow_d = prev_slow_q;
    marker_d    = marker_q;
    txr_d       = 1'b0;
    rxd_d       = rxd_q;
    en_d        = en_q;
    pop         = 1'b0;
    lead        = ~edge_q[0];
    capture     = cur_cfg.inverted_clock_phase ? lead : ~lead;
    s_lead      = sclk_s != slv_cfg.cpol;
    s_capture   = slv_cfg.inverted_clock_phase ? s_lead : ~s_lead;
    repeat_bug  = new_cfg.cs_hold_after_transfer && new_cfg.serial_clock_divisor == DIV_ONE
                  && new_cs == last_cs_q && idle_seen_q;
    extra       = new_cfg.serial_clock_divisor == DIV_ONE
                  && ((new_cfg.width_code[0] && new_cfg.width_code < WIDTH_16)
                  || (new_cfg.cpol && !new_cfg.inverted_clock_phase && prev_slow_q));
    rxv_d       = (rxv_q && rx_ready) ? 1'b0 : rxv_q;

    if (fixed_select) begin
      dmahw_d = chip_select_config_regs[0].width_code != WIDTH_8;
    end else begin
      dmahw_d = new_cfg.width_code != WIDTH_8;
    end

    if (enable_cmd) begin
      en_d = 1'b1;
    end else if (disable_cmd && master_select_bit) begin
      en_d = 1'b0;
    end

    // Config writes while master is still clear kick the clock pin
    if (!master_select_bit && chip_select_config_regs != cfg_prev_q) begin
      sclk_d = ~sclk_q;
    end

    if (master_select_bit) begin
      miso_oe_d = 1'b0;
      unique case (state_q)
        SPIC_IDLE: begin
          if (en_q && fifo_valid) begin
            pop         = !repeat_bug;
            txr_d       = !repeat_bug;
            cur_cs_d    = new_cs;
            last_cs_d   = new_cs;
            marker_d    = fifo_word.final_word_marker;
            shreg_d     = fifo_word.data << (5'h10 - new_nbits);
            mosi_d      = shreg_d[15];
            sclk_d      = new_cfg.cpol;
            cs_n_d      = ~(4'h1 << new_cs);
            target_d    = {new_nbits, 1'b0} + (extra ? EXTRA_EDGES : 6'h00);
            prev_slow_d = new_cfg.serial_clock_divisor != DIV_ONE;
            idle_seen_d = 1'b0;
            cnt_d       = '0;
            edge_d      = '0;
            rxsh_d      = '0;
            state_d     = SPIC_SHIFT;
          end else if (!fifo_valid) begin
            idle_seen_d = 1'b1;
          end
        end
        SPIC_SHIFT: begin
          if (cnt_q >= div_eff - DIV_ONE) begin
            cnt_d  = '0;
            sclk_d = ~sclk_q;
            edge_d = edge_q + 6'h01;
            if (edge_q < {nbits, 1'b0}) begin
              // Leading-edge data is read one edge later to cover the synchroniser
              if (capture) begin
                if (!cur_cfg.inverted_clock_phase) begin
                  rxsh_d = {rxsh_q[14:0], miso_s};
                end
              end else if (edge_q != 6'h00 || cur_cfg.inverted_clock_phase) begin
                if (cur_cfg.inverted_clock_phase) begin
                  rxsh_d = {rxsh_q[14:0], miso_s};
                end
                shreg_d = shreg_q << 1;
                mosi_d  = shreg_q[14];
              end
            end
            if (edge_q + 6'h01 == target_q) begin
              rxd_d   = rxsh_d;
              rxv_d   = 1'b1;
              state_d = SPIC_IDLE;
              if (!cur_cfg.cs_hold_after_transfer
                  || (marker_q && (!fixed_select || !fifo_valid))) begin
                cs_n_d = CS_IDLE_N;
              end
            end
          end else begin
            cnt_d = cnt_q + 8'h01;
          end
        end
        default: state_d = SPIC_IDLE;
      endcase
    end else begin
      state_d = SPIC_IDLE;
      cs_n_d  = CS_IDLE_N;
      if (en_q && !ss_n_s) begin
        miso_oe_d = 1'b1;
        if (ss_prev_q) begin
          pop     = fifo_valid;
          shreg_d = fifo_valid ? fifo_word.data << (5'h10 - spic_nbits(slv_cfg.width_code))
                               : 16'h0000;
          miso_d  = shreg_d[15];
          scnt_d  = '0;
          rxsh_d  = '0;
        end else if (sclk_s != sclk_prev_q) begin
          if (s_capture) begin
            rxsh_d = {rxsh_q[14:0], mosi_s};
            scnt_d = scnt_q + 5'h01;
            if (scnt_q + 5'h01 == spic_nbits(slv_cfg.width_code)) begin
              rxd_d  = rxsh_d;
              rxv_d  = 1'b1;
              scnt_d = '0;
            end
          end else begin
            shreg_d = shreg_q << 1;
            miso_d  = shreg_q[14];
          end
        end
      end else begin
        miso_oe_d = 1'b0;
      end
    end

    txe_d = !fifo_valid && state_d == SPIC_IDLE;
    moe_d = master_select_bit && en_q;

    // Soft reset brings state, selects, enable, receive valid and output enables back to reset; serial clock keeps its level
    if (soft_reset_cmd) begin
      state_d     = SPIC_IDLE;
      cs_n_d      = CS_IDLE_N;
      en_d        = 1'b0;
      rxv_d       = 1'b0;
      miso_oe_d   = 1'b0;
      moe_d       = 1'b0;
      idle_seen_d = 1'b0;
      prev_slow_d = PREV_SLOW_RESET;
      txr_d       = 1'b0;
      pop         = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q     <= SPIC_IDLE;
      cfg_prev_q  <= '0;
      cnt_q       <= '0;
      edge_q      <= '0;
      target_q    <= '0;
      scnt_q      <= '0;
      shreg_q     <= '0;
      rxsh_q      <= '0;
      cur_cs_q    <= '0;
      last_cs_q   <= '0;
      cs_n_q      <= CS_IDLE_N;
      sclk_q      <= SCLK_RESET;
      mosi_q      <= 1'b0;
      miso_q      <= 1'b0;
      miso_oe_q   <= 1'b0;
      idle_seen_q <= 1'b0;
      prev_slow_q <= PREV_SLOW_RESET;
      marker_q    <= 1'b0;
      txr_q       <= 1'b0;
      txe_q       <= 1'b1;
      rxv_q       <= 1'b0;
      rxd_q       <= '0;
      en_q        <= 1'b0;
      dmahw_q     <= 1'b0;
      moe_q       <= 1'b0;
    end else begin
      state_q     <= state_d;
      cfg_prev_q  <= cfg_prev_d;
      cnt_q       <= cnt_d;
      edge_q      <= edge_d;
      target_q    <= target_d;
      scnt_q      <= scnt_d;
      shreg_q     <= shreg_d;
      rxsh_q      <= rxsh_d;
      cur_cs_q    <= cur_cs_d;
      last_cs_q   <= last_cs_d;
      cs_n_q      <= cs_n_d;
      sclk_q      <= sclk_d;
      mosi_q      <= mosi_d;
      miso_q      <= miso_d;
      miso_oe_q   <= miso_oe_d;
      idle_seen_q <= idle_seen_d;
      prev_slow_q <= prev_slow_d;
      marker_q    <= marker_d;
      txr_q       <= txr_d;
      txe_q       <= txe_d;
      rxv_q       <= rxv_d;
      rxd_q       <= rxd_d;
      en_q        <= en_d;
      dmahw_q     <= dmahw_d;
      moe_q       <= moe_d;
    end
  end

  assign transmit_ready_flag = txr_q;
  assign transmit_empty_flag = txe_q;
  assign dma_halfword        = dmahw_q;
  assign enabled             = en_q;
  assign rx_valid            = rxv_q;
  assign rx_data             = rxd_q;
  assign serial_clock_out    = sclk_q;
  assign mosi_out            = mosi_q;
  assign master_oe           = moe_q;
  assign cs_n_out            = cs_n_q;
  assign miso_out            = miso_q;
  assign miso_oe             = miso_oe_q;

endmodule

// ---- src/spic_pkg.sv ----
// Shared types and constants for the serial peripheral controller
package spic_pkg;

  localparam int unsigned NUM_CS   = 4;
  localparam int unsigned FIFO_W   = 32;
  localparam int unsigned FIFO_D   = 32;
  localparam int unsigned SHIFT_W  = 16;

  localparam logic [3:0] WIDTH_8     = 4'h0;
  localparam logic [3:0] WIDTH_16    = 4'h8;
  localparam logic [7:0] DIV_ONE     = 8'h01;
  localparam logic [3:0] CS_IDLE_N   = 4'hF;
  localparam logic [5:0] EXTRA_EDGES = 6'h02;
  localparam logic       SCLK_RESET  = 1'b0;
  localparam logic       PREV_SLOW_RESET = 1'b0;

  typedef struct packed {
    logic [7:0] serial_clock_divisor;
    logic [3:0] width_code;
    logic       cpol;
    logic       inverted_clock_phase;
    logic       cs_hold_after_transfer;
  } spic_cs_cfg_t;

  typedef struct packed {
    logic [6:0]  spare_hi;
    logic        final_word_marker;
    logic [3:0]  spare_mid;
    logic [3:0]  pcs;
    logic [15:0] data;
  } spic_tx_word_t;

  typedef enum logic [1:0] {
    SPIC_IDLE,
    SPIC_SHIFT
  } spic_state_t;

  // Number of bits in a word for a width code; codes past 16 bits saturate
  function automatic logic [4:0] spic_nbits(input logic [3:0] code);
    spic_nbits = (code > WIDTH_16) ? 5'h10 : 5'(code) + 5'h08;
  endfunction

endpackage

// ---- sim/spic_ctrl_props.sv ----
// Port-level assertions for the serial peripheral controller
`timescale 1ns/10ps

module spic_ctrl_props
  import spic_pkg::*;
(
  input wire logic                      sys_clk,
  input wire logic                      reset_n,
  input wire logic                      enable_cmd,
  input wire logic                      disable_cmd,
  input wire logic                      soft_reset_cmd,
  input wire logic                      master_select_bit,
  input wire logic                      fixed_select,
  input wire spic_cs_cfg_t [NUM_CS-1:0] chip_select_config_regs,
  input wire logic                      tx_valid,
  input wire spic_tx_word_t             tx_word,
  input wire logic                      tx_ready,
  input wire logic                      transmit_ready_flag,
  input wire logic                      transmit_empty_flag,
  input wire logic                      dma_halfword,
  input wire logic                      enabled,
  input wire logic                      serial_clock_out,
  input wire logic [NUM_CS-1:0]         cs_n_out
);
  logic marker_d;
  logic marker_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // Remembers an accepted final word until the select lines go idle
  always_comb begin
    marker_d = marker_q;
    if (cs_n_out == CS_IDLE_N) marker_d = 1'b0;
    if (tx_valid && tx_ready && tx_word.final_word_marker) marker_d = 1'b1;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) marker_q <= 1'b0;
    else marker_q <= marker_d;
  end

  a_dma_size_static: assert property (fixed_select && $past(fixed_select)
    && $past(reset_n) && $stable(chip_select_config_regs)
    |-> dma_halfword == (chip_select_config_regs[0].width_code != WIDTH_8))
    else $error("dma size does not follow configuration 0 width");
  a_final_word_release: assert property (fixed_select && marker_q
    && $rose(transmit_empty_flag) |-> ##[0:3] cs_n_out == CS_IDLE_N)
    else $error("select not released after final word");
  a_cs_one_low: assert property ($onehot0(~cs_n_out))
    else $error("more than one select low");
  a_half_period_div: assert property (!cs_n_out[0] && $changed(serial_clock_out)
    && chip_select_config_regs[0].serial_clock_divisor == 8'h02
    && $stable(chip_select_config_regs) |=> $stable(serial_clock_out))
    else $error("serial clock half period shorter than divisor");
  a_ready_one_pulse: assert property (transmit_ready_flag |=> !transmit_ready_flag)
    else $error("transmit ready longer than one cycle");
  a_slave_no_disable: assert property (!master_select_bit && enabled
    && disable_cmd && !soft_reset_cmd |=> enabled)
    else $error("slave engine disabled by command");
  a_master_disable: assert property (master_select_bit && disable_cmd
    && !enable_cmd && !soft_reset_cmd |=> !enabled)
    else $error("master engine not disabled");
  a_soft_reset_clear: assert property (soft_reset_cmd
    |=> !enabled ##[0:1] transmit_empty_flag)
    else $error("soft reset did not clear engine");
endmodule

bind spic_ctrl spic_ctrl_props spic_ctrl_props_i (
  .sys_clk(sys_clk), .reset_n(reset_n), .enable_cmd(enable_cmd), .disable_cmd(disable_cmd),
  .soft_reset_cmd(soft_reset_cmd), .master_select_bit(master_select_bit),
  .fixed_select(fixed_select), .chip_select_config_regs(chip_select_config_regs),
  .tx_valid(tx_valid), .tx_word(tx_word), .tx_ready(tx_ready),
  .transmit_ready_flag(transmit_ready_flag), .transmit_empty_flag(transmit_empty_flag),
  .dma_halfword(dma_halfword), .enabled(enabled), .serial_clock_out(serial_clock_out),
  .cs_n_out(cs_n_out)
);

// ---- sim/spic_periph_model.sv ----
// Behavioural serial peripheral and slave-mode bus master for the controller bench
`timescale 1ns/10ps

module spic_periph_model
  import spic_pkg::*;
#(
  parameter logic [15:0] REPLY = 16'hA5C3
) (
  input  wire logic              serial_clock_out,
  input  wire logic              mosi_out,
  input  wire logic [NUM_CS-1:0] cs_n_out,
  output logic                   miso_in,
  output logic                   sclk_in,
  output logic                   ss_n_in,
  output logic                   mosi_in,
  output int                     edge_cnt,
  output logic [15:0]            got_word,
  output logic [NUM_CS-1:0]      cs_seen
);
  logic [15:0] shreg;
  wire         sel = cs_n_out != CS_IDLE_N;
  wire         sel_d;

  // Clock edges in the same step as the select edge are settling, not data
  assign #1 sel_d = sel;

  initial begin
    {miso_in, sclk_in, mosi_in} = 3'h0;
    ss_n_in = 1'b1;
    edge_cnt = 0;
    got_word = 16'h0000;
    cs_seen = CS_IDLE_N;
    shreg = REPLY;
  end

  always @(posedge sel) begin
    edge_cnt = 0;
    got_word = 16'h0000;
    cs_seen = cs_n_out;
    shreg = REPLY;
    miso_in = REPLY[15];
  end

  // Released line no longer holds the last bit
  always @(negedge sel) miso_in = ~miso_in;

  always @(serial_clock_out) begin
    if (sel_d) begin
      edge_cnt++;
      if (serial_clock_out) got_word = {got_word[14:0], mosi_out};
      else begin
        shreg = {shreg[14:0], 1'b0};
        miso_in = shreg[15];
      end
    end
  end

  // One byte as bus master, 160 ns clock, data changes while clock is low
  task automatic drive_slave(input logic [7:0] b);
    ss_n_in = 1'b0;
    #200;
    for (int i = 7; i >= 0; i--) begin
      mosi_in = b[i];
      #80 sclk_in = 1'b1;
      #80 sclk_in = 1'b0;
    end
    #200 ss_n_in = 1'b1;
    mosi_in = ~mosi_in;
  endtask
endmodule

// ---- sim/spic_ctrl_test.sv ----
// Self-checking bench for the serial peripheral controller
`timescale 1ns/10ps

`define CHK(got, exp) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
      error_cnt++; \
      $display("unexpected at %0t: got %0h expected %0h", $time, (got), (exp)); \
    end \
  end

module spic_ctrl_test
  import spic_pkg::*;
;
  localparam logic [15:0] REPLY = 16'h5A3C;
  logic                      sys_clk = 1'b0;
  logic                      reset_n = 1'b0;
  logic                      enable_cmd, disable_cmd, soft_reset_cmd, master_select_bit;
  logic                      fixed_select, tx_valid, rx_ready, tx_ready, transmit_ready_flag;
  logic                      transmit_empty_flag, dma_halfword, enabled, rx_valid, master_oe;
  logic                      serial_clock_out, mosi_out, miso_in, sclk_in, ss_n_in, mosi_in;
  logic [1:0]                cs_select;
  spic_cs_cfg_t [NUM_CS-1:0] cfg;
  spic_tx_word_t             tx_word;
  logic [SHIFT_W-1:0]        rx_data, last_rx;
  logic [NUM_CS-1:0]         cs_n_out, cs_seen;
  logic [15:0]               got_word;
  int                        edge_cnt, frames, loads, nf, l0, error_cnt, samples_checked;

  spic_ctrl spic_ctrl_i (
    .sys_clk(sys_clk), .reset_n(reset_n), .enable_cmd(enable_cmd), .disable_cmd(disable_cmd),
    .soft_reset_cmd(soft_reset_cmd), .master_select_bit(master_select_bit),
    .fixed_select(fixed_select), .cs_select(cs_select), .chip_select_config_regs(cfg),
    .tx_valid(tx_valid), .tx_word(tx_word), .tx_ready(tx_ready),
    .transmit_ready_flag(transmit_ready_flag), .transmit_empty_flag(transmit_empty_flag),
    .dma_halfword(dma_halfword), .enabled(enabled), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ready(rx_ready), .serial_clock_out(serial_clock_out), .mosi_out(mosi_out),
    .master_oe(master_oe), .cs_n_out(cs_n_out), .miso_in(miso_in), .sclk_in(sclk_in),
    .ss_n_in(ss_n_in), .mosi_in(mosi_in), .miso_out(), .miso_oe()
  );

  spic_periph_model #(.REPLY(REPLY)) spic_periph_model_i (
    .serial_clock_out(serial_clock_out), .mosi_out(mosi_out), .cs_n_out(cs_n_out),
    .miso_in(miso_in), .sclk_in(sclk_in), .ss_n_in(ss_n_in), .mosi_in(mosi_in),
    .edge_cnt(edge_cnt), .got_word(got_word), .cs_seen(cs_seen)
  );

  always #5 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    if (rx_valid === 1'b1) begin
      frames++;
      last_rx = rx_data;
    end
    if (transmit_ready_flag === 1'b1) loads++;
  end

  function automatic spic_cs_cfg_t mk(input logic [7:0] dv, input logic [3:0] w,
                                      input logic pol, input logic ph, input logic hold);
    return '{dv, w, pol, ph, hold};
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic push(input logic [1:0] cs, input logic [15:0] d, input logic mark);
    @(posedge sys_clk);
    tx_valid <= 1'b1;
    tx_word <= '{7'h00, mark, 4'h0, {2'h0, cs}, d};
    @(posedge sys_clk);
    while (tx_ready !== 1'b1) @(posedge sys_clk);
    tx_valid <= 1'b0;
    nf++;
  endtask

  task automatic wait_frames();
    for (int g = 0; g < 3000 && frames < nf; g++) @(negedge sys_clk);
    `CHK(frames >= nf, 1'b1)
  endtask

  task automatic frame(input logic [1:0] cs, input int n, input int edges, input logic chk);
    push(cs, 16'h9C35, 1'b0);
    wait_frames();
    `CHK(edge_cnt, edges)
    `CHK(cs_seen, ~(4'h1 << cs))
    if (chk) begin
      `CHK(got_word, 16'h9C35 & (16'hFFFF >> (16 - n)))
      `CHK(last_rx, REPLY >> (16 - n))
    end
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    {enable_cmd, disable_cmd, soft_reset_cmd, master_select_bit, fixed_select} = 5'h00;
    {tx_valid, rx_ready, cs_select, tx_word} = {2'b01, 2'h0, 32'h0000_0000};
    {frames, loads, nf, error_cnt, samples_checked} = {5{32'sd0}};
    cfg = {NUM_CS{mk(8'h02, 4'h0, 1'b0, 1'b1, 1'b0)}};
    tick(10);
    reset_n <= 1'b1;
    tick(3);
    `CHK({transmit_empty_flag, tx_ready, cs_n_out}, {2'b11, CS_IDLE_N})
    master_select_bit <= 1'b1;
    tick(1);
    enable_cmd <= 1'b1;
    tick(1);
    enable_cmd <= 1'b0;
    for (int dv = 2; dv >= 1; dv--) begin
      for (int c = 0; c <= 8; c++) begin
        tick(1);
        cfg[0] <= mk(8'(dv), 4'(c), 1'b0, 1'b1, 1'b0);
        frame(2'h0, c + 8, 2 * (c + 8) + ((dv == 1 && c % 2 == 1) ? 2 : 0), dv == 2);
      end
    end
    tick(1);
    cfg[0] <= mk(8'h02, 4'h0, 1'b1, 1'b0, 1'b0);
    cfg[1] <= mk(8'h01, 4'h0, 1'b1, 1'b0, 1'b0);
    frame(2'h0, 8, 16, 1'b0);
    frame(2'h1, 8, 18, 1'b0);
    tick(1);
    cfg[0] <= mk(8'h01, 4'h0, 1'b1, 1'b0, 1'b0);
    frame(2'h0, 8, 16, 1'b0);
    frame(2'h1, 8, 16, 1'b0);
    tick(1);
    cfg[2] <= mk(8'h01, 4'h0, 1'b0, 1'b1, 1'b1);
    l0 = loads;
    frame(2'h2, 8, 16, 1'b0);
    tick(5);
    push(2'h2, 16'h00C6, 1'b0);
    nf++;
    wait_frames();
    tick(80);
    `CHK(frames, nf)
    `CHK(loads - l0, 2)
    soft_reset_cmd <= 1'b1;
    tick(1);
    soft_reset_cmd <= 1'b0;
    tick(3);
    `CHK({enabled, transmit_empty_flag, cs_n_out}, {2'b01, CS_IDLE_N})
    enable_cmd <= 1'b1;
    fixed_select <= 1'b1;
    cs_select <= 2'h3;
    cfg[3] <= mk(8'h02, 4'h0, 1'b0, 1'b1, 1'b1);
    cfg[0] <= mk(8'h02, 4'h2, 1'b0, 1'b1, 1'b0);
    tick(1);
    enable_cmd <= 1'b0;
    frame(2'h3, 8, 16, 1'b1);
    tick(4);
    `CHK({cs_n_out, dma_halfword}, {4'h7, 1'b1})
    `CHK(master_oe, 1'b1)
    push(2'h0, 16'h0012, 1'b1);
    wait_frames();
    tick(4);
    `CHK(cs_n_out, CS_IDLE_N)
    cfg[0] <= mk(8'h02, 4'h0, 1'b0, 1'b1, 1'b0);
    tick(3);
    `CHK(dma_halfword, 1'b0)
    fixed_select <= 1'b0;
    master_select_bit <= 1'b0;
    enable_cmd <= 1'b1;
    tick(1);
    enable_cmd <= 1'b0;
    l0 = int'(serial_clock_out);
    cfg[1] <= mk(8'h03, 4'h0, 1'b0, 1'b1, 1'b0);
    tick(2);
    `CHK(serial_clock_out, ~l0[0])
    spic_periph_model_i.drive_slave(8'h6B);
    nf++;
    wait_frames();
    `CHK(last_rx, 16'h006B)
    tick(1);
    disable_cmd <= 1'b1;
    tick(1);
    disable_cmd <= 1'b0;
    tick(2);
    `CHK(enabled, 1'b1)
    soft_reset_cmd <= 1'b1;
    tick(1);
    soft_reset_cmd <= 1'b0;
    tick(2);
    `CHK(enabled, 1'b0)
    finish_test();
  end

  initial begin
    #500000;
    error_cnt++;
    finish_test();
  end
endmodule
